// ===== qla_pkg.sv
/*
 Constants, types and register layout of the four-line serial adapter.
 Assumes a single 25 MHz clock and a synchronous active-high reset.
*/
// Behaviour
// - Clear-available strobe reaches one scanned line
// - Clear-available needs write, request; overrun suppresses
// - Entering receive mode clears available flag
// - Clear-status strobe clears edge detector, also on enable
// - Read strobe after status request clears; underflow blocks
// - Control strobe loads line control register
// - Data strobe loads transmit buffer of scanned line
// - Break strobe is data strobe and break enable
// - Scan bits decode to one-hot line selects
// - Edge detector compares held and live control input
// - Acknowledge copies control input into detector
// - Framing: start, 5-8 data, parity, 1-2 stops
// - Parity and framing error flags on receive
// - Overrun when previous character still unread
// - Bit timing from 16x clock per line
// - Available flag set on character, low clear resets it; a character ending in the same cycle wins
// - Reception starts on high-to-low input edge
// - Master reset: serial and end-of-character outputs high, flags cleared except buffer empty, which is set
// - Buffer empty allows low load strobe, LSB first
// - End-of-character after each character; idle high
// - Control strobe latches format into holding register
// - Low enables drive right-justified data and status
// - Input request on available+receive or transmit+framing
package qla_pkg;

	// ============================================================
	// Sizes
	localparam int LINES = 4;
	localparam int DATA_W = 8;
	localparam int REG_AW = 4;
	localparam int REG_DW = 16;

	// ============================================================
	// Software register map
	localparam logic [REG_AW-1:0] ADDR_FMT0 = 4'h0;
	localparam logic [REG_AW-1:0] ADDR_DIV0 = 4'h4;
	localparam logic [REG_AW-1:0] ADDR_FLAGS = 4'h8;
	localparam logic [REG_AW-1:0] ADDR_LINES = 4'h9;

	// Line format fields
	localparam int FMT_WL_LO = 0;
	localparam int FMT_WL_HI = 1;
	localparam int FMT_STOP2 = 2;
	localparam int FMT_NOPAR = 3;
	localparam int FMT_ODD = 4;
	localparam int FMT_W = 5;
	localparam logic [FMT_W-1:0] FMT_RST = 5'h03;

	// Line control byte fields, loaded from the multiplexor bus
	localparam int CTL_T = 0;
	localparam int CTL_R = 1;
	localparam int CTL_E = 2;
	localparam int CTL_TB = 3;
	localparam int CTL_ICS = 4;
	localparam int CTL_MT = 5;
	localparam int CTL_W = 6;
	localparam logic [CTL_W-1:0] CTL_RST = 6'h00;

	// Status byte fields returned to the multiplexor
	localparam int ST_PE = 0;
	localparam int ST_FE = 1;
	localparam int ST_OVR = 2;
	localparam int ST_AVAIL = 3;
	localparam int ST_TBE = 4;
	localparam int ST_CHG = 5;

	// ============================================================
	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int BAUD_RST = 9600;
	localparam int OVERSAMPLE = 16;
	localparam logic [REG_DW-1:0] DIV_RST =
		REG_DW'(CLK_HZ / (OVERSAMPLE * BAUD_RST));
	localparam logic [3:0] PH_MID = 4'h7;
	localparam logic [3:0] PH_LAST = 4'hf;

	// ============================================================
	// Types
	typedef enum logic [4:0] {
		SER_IDLE = 5'b00001,
		SER_START = 5'b00010,
		SER_DATA = 5'b00100,
		SER_PAR = 5'b01000,
		SER_STOP = 5'b10000
	} qla_ser_t;

	typedef struct packed {
		logic strobe;
		logic write;
		logic sel_a;
		logic sel_b;
		logic enable;
		logic [DATA_W-1:0] data;
	} qla_mux_req_t;

endpackage

// ===== qla_adapter.sv
/*
 Four-line asynchronous adapter: multiplexor strobe decode, line scan,
 control-line edge detectors and one serial transceiver per line.
 Assumes all inputs synchronous to clk_in and a one-cycle mux strobe.
*/
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module qla_adapter
	import qla_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [REG_AW-1:0] reg_addr_in,
	input wire logic [REG_DW-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [REG_DW-1:0] reg_rdata_out,
	input wire qla_mux_req_t mux_req_in,
	input wire logic mux_hold_in,
	output logic [DATA_W-1:0] mux_data_out,
	output logic mux_data_oe_out,
	output logic [1:0] scan_bits_out,
	output logic [LINES-1:0] in_data_req_out,
	output logic [LINES-1:0] in_status_req_out,
	input wire logic [LINES-1:0] rx_serial_in,
	input wire logic [LINES-1:0] ctrl_line_in,
	output logic [LINES-1:0] tx_serial_out,
	output logic [LINES-1:0] tx_char_done_out
);

	// ============================================================
	// Software registers
	logic [FMT_W-1:0] fmt_r [LINES];
	logic [REG_DW-1:0] div_r [LINES];
	logic [LINES-1:0] avail_w, pe_w, fe_w, ovr_w, tbe_w, chg_w;
	logic [LINES-1:0] idr_w, isr_w, so_w, done_w;
	logic [DATA_W-1:0] drv_w [LINES];
	logic [DATA_W-1:0] rd_bus;

	// Format register write acts as the control strobe of the line
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int k = 0; k < LINES; k++) begin
				fmt_r[k] <= FMT_RST;
				div_r[k] <= DIV_RST;
			end
		end else if (reg_wr_in) begin
			for (int k = 0; k < LINES; k++) begin
				if (reg_addr_in == ADDR_FMT0 + REG_AW'(k))
					fmt_r[k] <= reg_wdata_in[FMT_W-1:0];
				if (reg_addr_in == ADDR_DIV0 + REG_AW'(k))
					div_r[k] <= reg_wdata_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_FMT0, ADDR_FMT0 + 4'h1, ADDR_FMT0 + 4'h2,
				ADDR_FMT0 + 4'h3: begin
					reg_rdata_out <= REG_DW'(fmt_r[reg_addr_in[1:0]]);
				end
				ADDR_DIV0, ADDR_DIV0 + 4'h1, ADDR_DIV0 + 4'h2,
				ADDR_DIV0 + 4'h3: begin
					reg_rdata_out <= div_r[reg_addr_in[1:0]];
				end
				ADDR_FLAGS: begin
					reg_rdata_out <= {ovr_w, fe_w, pe_w, avail_w};
				end
				ADDR_LINES: begin
					reg_rdata_out <= {8'h00, tbe_w, chg_w};
				end
				default: begin
					reg_rdata_out <= '0;
				end
			endcase
		end else begin
			reg_rdata_out <= '0;
		end
	end

	// ============================================================
	// Line scan and strobe decode
	logic [1:0] scan_r;
	logic [LINES-1:0] line_sel;
	logic bus_acc, rd_acc;

	always_ff @(posedge clk_in) begin
		if (rst_in)
			scan_r <= 2'h0;
		else if (!mux_hold_in)
			scan_r <= scan_r + 2'h1;
	end

	assign scan_bits_out = scan_r;
	assign line_sel = LINES'(1) << scan_r;
	assign bus_acc = mux_req_in.strobe & mux_req_in.enable;
	assign rd_acc = bus_acc & !mux_req_in.write;

	// Lines drive a shared bus only while selected
	always_comb begin
		rd_bus = '0;
		for (int k = 0; k < LINES; k++)
			rd_bus = rd_bus | drv_w[k];
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mux_data_out <= '0;
			mux_data_oe_out <= 1'b0;
		end else begin
			mux_data_oe_out <= rd_acc;
			if (rd_acc)
				mux_data_out <= rd_bus;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			in_data_req_out <= '0;
			in_status_req_out <= '0;
			tx_serial_out <= '1;
			tx_char_done_out <= '1;
		end else begin
			in_data_req_out <= idr_w;
			in_status_req_out <= isr_w;
			tx_serial_out <= so_w;
			tx_char_done_out <= done_w;
		end
	end

	// ============================================================
	// Per-line logic
	genvar i;
	generate
		for (i = 0; i < LINES; i++) begin : g_line
			logic [CTL_W-1:0] ctl_r, ctl_prev_r;
			logic ref_r, ovr_base_r, brk_r;
			logic clr_av, clr_st, ctl_ld, dat_st, brk;
			logic rx_avail_clear_n, tx_load_n, rde_n, swe_n;
			logic underflow, inhibit, tick;
			logic [REG_DW-1:0] div_cnt_r;
			qla_ser_t rs_r, ts_r;
			logic [3:0] rph_r, tph_r;
			logic [2:0] ridx_r, tidx_r;
			logic [DATA_W-1:0] rsh_r, rbuf_r, tsh_r, tbuf_r;
			logic rpar_r, rprev_r, rx_done, av_r, pe_r, fe_r, ovr_r;
			logic tbe_r, so_r, tpar_r, stp_r, done_r, take;
			logic [2:0] last_idx;
			logic [DATA_W-1:0] status;

			assign last_idx = {1'b1, fmt_r[i][FMT_WL_HI:FMT_WL_LO]};
			assign underflow = tbe_r & (ts_r == SER_IDLE);
			assign inhibit = ovr_r & !ovr_base_r;

			// Strobe steering to this line
			assign clr_av = (line_sel[i] & bus_acc & mux_req_in.write
				& idr_w[i] & !inhibit)
				| (ctl_r[CTL_R] & !ctl_prev_r[CTL_R]);
			assign clr_st = (line_sel[i] & rd_acc & isr_w[i] & !underflow)
				| (ctl_r[CTL_ICS] & !ctl_prev_r[CTL_ICS]);
			assign ctl_ld = line_sel[i] & bus_acc & !mux_req_in.sel_a
				& mux_req_in.sel_b & mux_req_in.write;
			assign dat_st = line_sel[i] & bus_acc & !mux_req_in.sel_a
				& !mux_req_in.sel_b & mux_req_in.write;
			assign brk = dat_st & ctl_r[CTL_TB];
			assign rx_avail_clear_n = !clr_av;
			assign tx_load_n = !dat_st;

			// Tristate-style output enables, active low
			assign rde_n = !(line_sel[i] & !mux_req_in.sel_a
				& !mux_req_in.sel_b);
			assign swe_n = !line_sel[i] | !rde_n;
			assign status = {2'h0, chg_w[i], tbe_r, av_r, ovr_r, fe_r, pe_r};
			assign drv_w[i] = (rde_n ? 8'h00 : rbuf_r)
				| (swe_n ? 8'h00 : status);

			assign chg_w[i] = ref_r ^ ctrl_line_in[i];
			assign idr_w[i] = (av_r & ctl_r[CTL_R])
				| (ctl_r[CTL_T] & fe_r);
			assign isr_w[i] = (ctl_r[CTL_ICS] & chg_w[i])
				| (ctl_r[CTL_MT] & underflow);
			assign avail_w[i] = av_r;
			assign pe_w[i] = pe_r;
			assign fe_w[i] = fe_r;
			assign ovr_w[i] = ovr_r;
			assign tbe_w[i] = tbe_r;
			assign so_w[i] = so_r & !brk_r;
			assign done_w[i] = done_r;

			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					ctl_r <= CTL_RST;
					ctl_prev_r <= CTL_RST;
					ref_r <= 1'b0;
					ovr_base_r <= 1'b0;
					brk_r <= 1'b0;
				end else begin
					ctl_prev_r <= ctl_r;
					if (ctl_ld)
						ctl_r <= mux_req_in.data[CTL_W-1:0];
					if (clr_st)
						ref_r <= ctrl_line_in[i];
					if (!idr_w[i])
						ovr_base_r <= ovr_r;
					if (brk)
						brk_r <= 1'b1;
					else if (dat_st)
						brk_r <= 1'b0;
				end
			end

			// 16x bit clock enable
			always_ff @(posedge clk_in) begin
				if (rst_in || div_cnt_r == 16'h0000)
					div_cnt_r <= div_r[i] - 16'h0001;
				else
					div_cnt_r <= div_cnt_r - 16'h0001;
			end
			assign tick = (div_cnt_r == 16'h0000) && !rst_in;

			// Receiver sequencing
			assign rx_done = (rs_r == SER_STOP) && tick && rph_r == PH_LAST;

			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					rs_r <= SER_IDLE;
					rph_r <= 4'h0;
					ridx_r <= 3'h0;
					rsh_r <= '0;
					rpar_r <= 1'b0;
					rprev_r <= 1'b1;
				end else begin
					rprev_r <= rx_serial_in[i];
					if (tick)
						rph_r <= rph_r + 4'h1;
					case (rs_r)
						SER_IDLE: begin
							rph_r <= 4'h0;
							if (rprev_r && !rx_serial_in[i])
								rs_r <= SER_START;
						end
						SER_START: begin
							if (tick && rph_r == PH_MID) begin
								rph_r <= 4'h0;
								ridx_r <= 3'h0;
								rsh_r <= '0;
								rpar_r <= 1'b0;
								rs_r <= rx_serial_in[i] ? SER_IDLE : SER_DATA;
							end
						end
						SER_DATA: begin
							if (tick && rph_r == PH_LAST) begin
								rsh_r[ridx_r] <= rx_serial_in[i];
								rpar_r <= rpar_r ^ rx_serial_in[i];
								ridx_r <= ridx_r + 3'h1;
								if (ridx_r == last_idx)
									rs_r <= fmt_r[i][FMT_NOPAR] ?
										SER_STOP : SER_PAR;
							end
						end
						SER_PAR: begin
							if (tick && rph_r == PH_LAST) begin
								rpar_r <= rpar_r ^ rx_serial_in[i];
								rs_r <= SER_STOP;
							end
						end
						SER_STOP: begin
							if (rx_done)
								rs_r <= SER_IDLE;
						end
						default: begin
							rs_r <= SER_IDLE;
						end
					endcase
				end
			end

			// Receive buffer and flags
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					rbuf_r <= '0;
					av_r <= 1'b0;
					pe_r <= 1'b0;
					fe_r <= 1'b0;
					ovr_r <= 1'b0;
				end else if (rx_done) begin
					rbuf_r <= rsh_r;
					av_r <= 1'b1;
					pe_r <= !fmt_r[i][FMT_NOPAR]
						& (rpar_r ^ fmt_r[i][FMT_ODD]);
					fe_r <= !rx_serial_in[i];
					ovr_r <= av_r;
				end else if (!rx_avail_clear_n) begin
					av_r <= 1'b0;
				end
			end

			// Transmit buffer
			assign take = (ts_r == SER_IDLE) && !tbe_r;

			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					tbe_r <= 1'b1;
					tbuf_r <= '0;
				end else if (take) begin
					tbe_r <= 1'b1;
				end else if (!tx_load_n && tbe_r) begin
					tbuf_r <= mux_req_in.data;
					tbe_r <= 1'b0;
				end
			end

			// Transmitter sequencing
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					ts_r <= SER_IDLE;
					so_r <= 1'b1;
					done_r <= 1'b1;
					tph_r <= 4'h0;
					tidx_r <= 3'h0;
					tsh_r <= '0;
					tpar_r <= 1'b0;
					stp_r <= 1'b0;
				end else begin
					if (tick)
						tph_r <= tph_r + 4'h1;
					case (ts_r)
						SER_IDLE: begin
							so_r <= 1'b1;
							tph_r <= 4'h0;
							if (take) begin
								tsh_r <= tbuf_r;
								so_r <= 1'b0;
								ts_r <= SER_START;
							end
						end
						SER_START: begin
							if (tick)
								done_r <= 1'b0;
							if (tick && tph_r == PH_LAST) begin
								so_r <= tsh_r[0];
								tpar_r <= tsh_r[0];
								tsh_r <= tsh_r >> 1;
								tidx_r <= 3'h0;
								ts_r <= SER_DATA;
							end
						end
						SER_DATA: begin
							if (tick && tph_r == PH_LAST) begin
								tidx_r <= tidx_r + 3'h1;
								if (tidx_r == last_idx) begin
									stp_r <= fmt_r[i][FMT_STOP2];
									if (fmt_r[i][FMT_NOPAR]) begin
										so_r <= 1'b1;
										ts_r <= SER_STOP;
									end else begin
										so_r <= tpar_r ^ fmt_r[i][FMT_ODD];
										ts_r <= SER_PAR;
									end
								end else begin
									so_r <= tsh_r[0];
									tpar_r <= tpar_r ^ tsh_r[0];
									tsh_r <= tsh_r >> 1;
								end
							end
						end
						SER_PAR: begin
							if (tick && tph_r == PH_LAST) begin
								so_r <= 1'b1;
								ts_r <= SER_STOP;
							end
						end
						SER_STOP: begin
							if (tick && tph_r == PH_LAST) begin
								if (stp_r) begin
									stp_r <= 1'b0;
								end else begin
									done_r <= 1'b1;
									ts_r <= SER_IDLE;
								end
							end
						end
						default: begin
							ts_r <= SER_IDLE;
						end
					endcase
				end
			end
		end
	endgenerate

endmodule

// ===== qla_adapter_asserts.sv
/*
 Port checker for the four-line adapter, bound into qla_adapter.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module qla_adapter_chk
	import qla_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [REG_DW-1:0] reg_rdata_out,
	input wire qla_mux_req_t mux_req_in,
	input wire logic mux_hold_in,
	input wire logic [DATA_W-1:0] mux_data_out,
	input wire logic mux_data_oe_out,
	input wire logic [1:0] scan_bits_out,
	input wire logic [LINES-1:0] in_data_req_out,
	input wire logic [LINES-1:0] in_status_req_out,
	input wire logic [LINES-1:0] tx_serial_out,
	input wire logic [LINES-1:0] tx_char_done_out
);
	// ==========
	// Port relations
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	chk_reset_lines: assert property (
		$fell(rst_in) |-> tx_serial_out == 4'hf && tx_char_done_out == 4'hf)
		else $error("serial lines not idle after reset");
	chk_reset_regs: assert property (
		$fell(rst_in) |-> scan_bits_out == 2'h0 && in_data_req_out == 4'h0
		&& in_status_req_out == 4'h0 && reg_rdata_out == 16'h0)
		else $error("outputs not cleared after reset");
	chk_read_oe: assert property (
		mux_req_in.strobe && mux_req_in.enable && !mux_req_in.write
		|=> mux_data_oe_out)
		else $error("read strobe gave no output enable");
	chk_oe_cause: assert property (
		mux_data_oe_out |-> $past(mux_req_in.strobe && mux_req_in.enable
		&& !mux_req_in.write))
		else $error("output enable without read strobe");
	chk_scan_step: assert property (
		!mux_hold_in && !rst_in
		|=> scan_bits_out == $past(scan_bits_out) + 2'h1)
		else $error("scan counter did not step");
	chk_scan_hold: assert property (
		mux_hold_in |=> $stable(scan_bits_out))
		else $error("scan counter moved while held");
	chk_done_start: assert property (
		$fell(tx_char_done_out[0]) |-> ##[0:1] !tx_serial_out[0])
		else $error("end of character fell without start bit");
	chk_data_hold: assert property (
		!mux_data_oe_out && !$past(rst_in) |-> $stable(mux_data_out))
		else $error("mux data changed without a read");
endmodule
bind qla_adapter qla_adapter_chk chk_u (.clk_in, .rst_in, .reg_rdata_out,
	.mux_req_in, .mux_hold_in, .mux_data_out, .mux_data_oe_out,
	.scan_bits_out, .in_data_req_out, .in_status_req_out, .tx_serial_out,
	.tx_char_done_out);

// ===== qla_mux_model.sv
/*
 Multiplexor unit model: issues one strobe at a time on a chosen line.
 Assumes the adapter's free-running scan counter and the shared clock.
*/
`timescale 1ns/10ps
module qla_mux_model
	import qla_pkg::*;
(
	input wire logic clk_in,
	input wire logic [1:0] scan_in,
	output qla_mux_req_t req_out,
	output logic hold_out
);
	initial begin
		req_out = '0;
		hold_out = 1'b0;
	end
	// Freeze the scan on the line, then pulse; wab = write,a,b,enable
	task automatic op(input logic [1:0] ln, input logic [3:0] wab,
		input logic [7:0] d);
		@(posedge clk_in);
		while (scan_in !== ln - 2'h1)
			@(posedge clk_in);
		hold_out <= 1'b1;
		req_out <= {1'b1, wab, d};
		@(posedge clk_in);
		req_out.strobe <= 1'b0;
		hold_out <= 1'b0;
	endtask
endmodule

// ===== testbench.sv
/*
 Self-checking bench for the four-line adapter.
 Assumes qla_mux_model as the multiplexor and serial lines driven here.
*/
`timescale 1ns/10ps
module testbench
	import qla_pkg::*;
;
	logic clk_in, rst_in, reg_wr_in, reg_rd_in, mux_hold_in, mux_data_oe_out;
	logic [3:0] reg_addr_in, rx_serial_in, ctrl_line_in, tx_serial_out;
	logic [3:0] tx_char_done_out, in_data_req_out, in_status_req_out;
	logic [15:0] reg_wdata_in, reg_rdata_out;
	logic [7:0] mux_data_out;
	logic [1:0] scan_bits_out;
	qla_mux_req_t mux_req_in;
	logic [10:0] f;
	int i, n, cycles, n_mismatch, total_checks;
	logic [19:0] rows [5] = '{20'h00003, 20'h400a2, 20'h80000, 20'h900f0,
		20'hc0000};
	qla_adapter dut_u (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .mux_req_in, .mux_hold_in,
		.mux_data_out, .mux_data_oe_out, .scan_bits_out, .in_data_req_out,
		.in_status_req_out, .rx_serial_in, .ctrl_line_in, .tx_serial_out,
		.tx_char_done_out);
	qla_mux_model m_u (.clk_in, .scan_in(scan_bits_out),
		.req_out(mux_req_in), .hold_out(mux_hold_in));
	// ==========
	// Tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		chk("reg", e, reg_rdata_out);
		@(posedge clk_in);
	endtask
	// Frame of 8 data bits, even parity flipped by pb, one stop, 16 clocks a bit
	task automatic ser(input int ln, input logic [7:0] d, input logic pb, sb);
		f = {~sb, ^d ^ pb, d, 1'b0};
		for (int k = 0; k < 11; k++) begin
			rx_serial_in[ln] <= f[k];
			repeat (16) @(posedge clk_in);
		end
		rx_serial_in[ln] <= 1'b1;
		repeat (32) @(posedge clk_in);
	endtask
	// ==========
	// Clock, timeout, sequence
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 10000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		rst_in = 1'b1;
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
		rx_serial_in = 4'hf;
		ctrl_line_in = 4'h0;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		wr(4'h8, 16'hffff);
		for (i = 0; i < 5; i++)
			rd(rows[i][19:16], rows[i][15:0]);
		for (i = 4; i < 8; i++)
			wr(4'(i), 16'h0001);
		// Let the divider count loaded at reset run out first
		repeat (170) @(posedge clk_in);
		m_u.op(2'h0, 4'h9, 8'ha5);
		f = {1'b1, ^8'ha5, 8'ha5, 1'b0};
		n = 0;
		while (tx_serial_out[0] !== 1'b0 && n < 99) begin
			@(posedge clk_in);
			n++;
		end
		repeat (8) @(posedge clk_in);
		for (i = 0; i < 11; i++) begin
			chk("tx_bit", 16'(f[i]), 16'(tx_serial_out[0]));
			repeat (16) @(posedge clk_in);
		end
		chk("tx_done", 16'h1, 16'(tx_char_done_out[0]));
		m_u.op(2'h1, 4'hb, 8'h02);
		ser(1, 8'h3c, 1'b0, 1'b0);
		rd(4'h8, 16'h0002);
		chk("data_req", 16'h1, 16'(in_data_req_out[1]));
		m_u.op(2'h1, 4'h1, 8'h00);
		@(negedge clk_in);
		chk("mux_oe", 16'h1, 16'(mux_data_oe_out));
		chk("mux_data", 16'h003c, 16'(mux_data_out));
		m_u.op(2'h1, 4'hf, 8'h00);
		rd(4'h8, 16'h0000);
		ser(1, 8'h55, 1'b1, 1'b0);
		rd(4'h8, 16'h0022);
		ser(1, 8'h0f, 1'b0, 1'b1);
		rd(4'h8, 16'h2202);
		m_u.op(2'h1, 4'hf, 8'h00);
		rd(4'h8, 16'h2202);
		// Odd parity, 8 bits, one stop on line 1
		wr(4'h1, 16'h0013);
		rd(4'h1, 16'h0013);
		ser(1, 8'h55, 1'b1, 1'b0);
		rd(4'h8, 16'h2002);
		ctrl_line_in <= 4'h8;
		m_u.op(2'h3, 4'hb, 8'h10);
		m_u.op(2'h2, 4'hb, 8'h10);
		repeat (4) @(posedge clk_in);
		chk("sts_req", 16'h0, 16'(in_status_req_out));
		ctrl_line_in <= 4'hc;
		repeat (4) @(posedge clk_in);
		chk("sts_req", 16'h4, 16'(in_status_req_out));
		m_u.op(2'h2, 4'h5, 8'h00);
		@(negedge clk_in);
		chk("mux_data", 16'h0030, 16'(mux_data_out));
		repeat (4) @(posedge clk_in);
		chk("sts_req", 16'h4, 16'(in_status_req_out));
		m_u.op(2'h2, 4'h9, 8'h00);
		m_u.op(2'h2, 4'h5, 8'h00);
		repeat (4) @(posedge clk_in);
		chk("sts_req", 16'h0, 16'(in_status_req_out));
		m_u.op(2'h3, 4'hb, 8'h08);
		m_u.op(2'h3, 4'h9, 8'h00);
		repeat (300) @(posedge clk_in);
		chk("brk", 16'h0, 16'(tx_serial_out[3]));
		m_u.op(2'h3, 4'hb, 8'h00);
		m_u.op(2'h3, 4'h9, 8'hff);
		repeat (300) @(posedge clk_in);
		chk("brk", 16'h1, 16'(tx_serial_out[3]));
		rst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		rd(4'h8, 16'h0000);
		chk("tx", 16'h00ff, {8'h00, tx_char_done_out, tx_serial_out});
		summarize();
	end
endmodule
